// >>> rtl/thmc_pkg.sv
// Package: mode encodings, widths, reset values and the trigger bundle of the timer mode control
package thmc_pkg;
   // ==========================================================
   // Widths and reset values
   localparam int THMC_CW = 8;
   localparam logic [7:0] THMC_CNT_RST = 8'h00;
   localparam logic [7:0] THMC_PER_RST = 8'hFF;
   // ==========================================================
   // Mode classes (upper two bits of the mode field)
   localparam logic [1:0] THMC_CLS_FREE = 2'h0;
   localparam logic [1:0] THMC_CLS_ONES = 2'h1;
   localparam logic [1:0] THMC_CLS_MONO = 2'h2;
   localparam logic [1:0] THMC_CLS_RSVD = 2'h3;
   // ==========================================================
   // Variants (lower three bits of the mode field)
   localparam logic [2:0] THMC_V0 = 3'h0;
   localparam logic [2:0] THMC_V1 = 3'h1;
   localparam logic [2:0] THMC_V2 = 3'h2;
   localparam logic [2:0] THMC_V3 = 3'h3;
   localparam logic [2:0] THMC_V4 = 3'h4;
   localparam logic [2:0] THMC_V5 = 3'h5;
   localparam logic [2:0] THMC_V6 = 3'h6;
   localparam logic [2:0] THMC_V7 = 3'h7;
   // ==========================================================
   // Mode field layout
   typedef struct packed {
      logic [1:0] cls;  // Class
      logic [2:0] var_sel;  // Variant
   } thmc_mode_t;
   // Decoded trigger events of the external reset signal
   typedef struct packed {
      logic rise;  // Rising edge
      logic fall;  // Falling edge
      logic level;  // Current level
   } thmc_trig_t;
   // Arm state of edge-started modes
   typedef enum logic [1:0] {
      THMC_IDLE = 2'b00,
      THMC_WAIT = 2'b01,
      THMC_RUN = 2'b10
   } thmc_state_t;
endpackage : thmc_pkg

// >>> rtl/thmc_edge.sv
// Edge detector for the external reset signal, masked while in debug
module thmc_edge (
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // Signal in
   input wire logic ers_i,
   input wire logic debug_i,
   // Decoded events
   output thmc_pkg::thmc_trig_t trig_o
);
   import thmc_pkg::*;
   logic prev_ff;  // Last sampled level
   logic armed_ff;  // History holds a real sample
   // ==========================================================
   // Level history; the first sample after reset only primes it, so a
   // signal that already stands high at release gives no false edge
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         prev_ff <= 1'b0;
         armed_ff <= 1'b0;
      end else begin
         prev_ff <= ers_i;
         armed_ff <= 1'b1;
      end
   end
   // ==========================================================
   // Event decode; debug blocks edges, the user freezes the level
   // debug masks edge events, not the level
   always_comb begin
      trig_o.rise = armed_ff && !debug_i && ers_i && !prev_ff;
      trig_o.fall = armed_ff && !debug_i && !ers_i && prev_ff;
      trig_o.level = ers_i;
   end
endmodule : thmc_edge

// >>> rtl/thmc_ctrl.sv
// Top: mode control, counter and period match of the hardware-limit period timer
module thmc_ctrl (
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // Software control
   input wire logic run_set_i,
   input wire logic run_clr_i,
   input thmc_pkg::thmc_mode_t mode_i,
   input wire logic [7:0] period_value_i,
   input wire logic debug_i,
   // External reset signal
   input wire logic ext_reset_signal_i,
   // Status
   output logic run_o,
   output logic [7:0] count_value_o,
   output logic match_o,
   output logic counting_o
);
   import thmc_pkg::*;

   // ==========================================================
   // Declarations
   logic run_ff;  // Run bit
   logic nxt_run;
   logic [7:0] cnt_ff;  // Count register
   logic [7:0] nxt_cnt;
   logic match_ff;  // Match pulse register
   logic cnt_en_ff;  // Counting indicator
   thmc_state_t st_ff;  // Arm state
   thmc_state_t nxt_st;
   thmc_trig_t trig;  // Decoded events
   logic lvl;  // Effective level, frozen in debug
   logic lvl_ff;  // Level captured outside debug
   logic run_eff;  // Run bit after this cycle's software write
   logic anyedge;
   logic start_ev;  // Qualifying start event
   logic rst_ev;  // Counter reset request
   logic gate;  // Counting allowed this cycle
   logic hit;  // Count equals period
   logic step;  // Counter advances or wraps this cycle
   logic edge_mode;  // Mode waits for an edge
   logic stop_clr;  // Match clears run bit
   logic rsvd;  // Reserved encoding

   // ==========================================================
   // Edge detector instance
   thmc_edge u_edge (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .ers_i(ext_reset_signal_i),
      .debug_i(debug_i),
      .trig_o(trig)
   );

   // ==========================================================
   // Level held steady while debug is active
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         lvl_ff <= 1'b0;
      end else if (!debug_i) begin
         lvl_ff <= trig.level;
      end
   end
   assign lvl = debug_i ? lvl_ff : trig.level;
   assign anyedge = trig.rise || trig.fall;
   assign run_eff = run_set_i || (run_ff && !run_clr_i);
   assign hit = (cnt_ff == period_value_i);

   // ==========================================================
   // Mode decode: start, reset and gate terms per class and variant
   always_comb begin
      start_ev = 1'b0;
      rst_ev = 1'b0;
      gate = 1'b0;
      edge_mode = 1'b0;
      stop_clr = 1'b0;
      rsvd = 1'b0;
      unique case (mode_i.cls)
         THMC_CLS_FREE: begin
            unique case (mode_i.var_sel)
               THMC_V0: gate = 1'b1;
               THMC_V1: gate = lvl;
               THMC_V2: gate = !lvl;
               THMC_V3: begin
                  gate = 1'b1;
                  rst_ev = anyedge;
               end
               THMC_V4: begin
                  gate = 1'b1;
                  rst_ev = trig.rise;
               end
               THMC_V5: begin
                  gate = 1'b1;
                  rst_ev = trig.fall;
               end
               THMC_V6: begin
                  gate = lvl;
                  rst_ev = !lvl;
               end
               THMC_V7: begin
                  gate = !lvl;
                  rst_ev = lvl;
               end
            endcase
         end
         THMC_CLS_ONES: begin
            stop_clr = 1'b1;
            unique case (mode_i.var_sel)
               THMC_V0: start_ev = 1'b1;
               THMC_V1: start_ev = trig.rise;
               THMC_V2: start_ev = trig.fall;
               THMC_V3: start_ev = anyedge;
               THMC_V4: begin
                  start_ev = trig.rise;
                  rst_ev = trig.rise;
               end
               THMC_V5: begin
                  start_ev = trig.fall;
                  rst_ev = trig.fall;
               end
               THMC_V6: begin
                  start_ev = trig.rise;
                  rst_ev = !lvl;
               end
               THMC_V7: begin
                  start_ev = trig.fall;
                  rst_ev = lvl;
               end
            endcase
            edge_mode = (mode_i.var_sel != THMC_V0);
         end
         THMC_CLS_MONO: begin
            unique case (mode_i.var_sel)
               THMC_V1: start_ev = trig.rise;
               THMC_V2: start_ev = trig.fall;
               THMC_V3: start_ev = anyedge;
               THMC_V6: begin
                  gate = lvl;
                  rst_ev = !lvl;
               end
               THMC_V7: begin
                  gate = !lvl;
                  rst_ev = lvl;
               end
               default: rsvd = 1'b1;
            endcase
            edge_mode = (mode_i.var_sel inside {THMC_V1, THMC_V2, THMC_V3});
         end
         THMC_CLS_RSVD: rsvd = 1'b1;
      endcase
   end

   // ==========================================================
   // Arm state: idle until run, wait for edge, then run
   always_comb begin
      nxt_st = st_ff;
      if (!run_ff || rsvd) begin
         nxt_st = THMC_IDLE;
      end else begin
         unique case (st_ff)
            THMC_IDLE: nxt_st = THMC_WAIT;
            THMC_WAIT: if (start_ev) nxt_st = THMC_RUN;
            THMC_RUN: if (hit && edge_mode && !stop_clr) nxt_st = THMC_WAIT;
            default: nxt_st = THMC_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_ff <= THMC_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ==========================================================
   // Run bit: software set/clear; one-shot match clears it
   always_comb begin
      nxt_run = run_eff;
      if (run_ff && st_ff == THMC_RUN && hit && stop_clr && !run_set_i) begin
         nxt_run = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         run_ff <= 1'b0;
      end else begin
         run_ff <= nxt_run;
      end
   end

   // ==========================================================
   // Counter next value
   always_comb begin
      nxt_cnt = cnt_ff;
      step = 1'b0;
      if (!run_ff || rsvd) begin
         nxt_cnt = cnt_ff;
      end else if (rst_ev && (st_ff == THMC_RUN || mode_i.cls != THMC_CLS_ONES)) begin
         nxt_cnt = THMC_CNT_RST;
      end else if (mode_i.cls == THMC_CLS_FREE || (mode_i.cls == THMC_CLS_MONO && !edge_mode)) begin
         if (gate) begin
            step = 1'b1;
            nxt_cnt = hit ? THMC_CNT_RST : cnt_ff + 8'h01;
         end
      end else if (st_ff == THMC_RUN) begin
         step = 1'b1;
         nxt_cnt = hit ? THMC_CNT_RST : cnt_ff + 8'h01;
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_ff <= THMC_CNT_RST;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   // ==========================================================
   // Status registers
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         match_ff <= 1'b0;
         cnt_en_ff <= 1'b0;
      end else begin
         // Only a real count step off the period is a match, not a parked zero
         match_ff <= step && hit;
         cnt_en_ff <= (nxt_cnt != cnt_ff);
      end
   end

   assign run_o = run_ff;
   assign count_value_o = cnt_ff;
   assign match_o = match_ff;
   assign counting_o = cnt_en_ff;
endmodule : thmc_ctrl

// >>> bench/thmc_ers_model.sv
// Model of the on-chip source of the external reset signal
module thmc_ers_model (
   // Clock
   input wire logic clk_i,
   // Level asked for by the bench
   input wire logic want_i,
   // External reset signal
   output logic ers_o
);
   timeunit 1ns / 1ns;
   int gap = 6; // Clocks since the last edge
   initial ers_o = 1'b0;
   always @(posedge clk_i) begin
      if (want_i != ers_o && gap >= 6) begin
         ers_o <= #1 want_i;
         gap <= 0;
      end else if (gap < 6) begin
         gap <= gap + 1;
      end
   end
endmodule : thmc_ers_model

// >>> bench/thmc_ctrl_monitor.sv
// Checker: timing properties at the ports of the timer mode control
module thmc_ctrl_monitor (
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // Watched inputs
   input wire logic run_set_i,
   input wire logic run_clr_i,
   input wire thmc_pkg::thmc_mode_t mode_i,
   input wire logic debug_i,
   input wire logic ext_reset_signal_i,
   // Watched outputs
   input wire logic run_o,
   input wire logic [7:0] count_value_o,
   input wire logic match_o
);
   timeunit 1ns / 1ns;
   import thmc_pkg::*;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   // Frozen count in reserved modes
   property p_rsvd; $past(mode_i.cls) == THMC_CLS_RSVD |-> $stable(count_value_o); endproperty
   a_rsvd: assert property (p_rsvd) else $error("count moved in reserved class");
   property p_mrsv; $past(mode_i) == 5'h10 |-> $stable(count_value_o); endproperty
   a_mrsv: assert property (p_mrsv) else $error("count moved in reserved variant");
   // Software gate halts the count
   property p_halt;
      $past(mode_i) == 5'h00 && !$past(run_o) && !$past(run_set_i) |-> $stable(count_value_o);
   endproperty
   a_halt: assert property (p_halt) else $error("count moved with run bit clear");
   property p_set; run_set_i |=> run_o; endproperty
   a_set: assert property (p_set) else $error("run bit not set");
   property p_clr; run_clr_i && !run_set_i |=> !run_o; endproperty
   a_clr: assert property (p_clr) else $error("run bit not cleared");
   // Match ends the cycle
   property p_osm;
      match_o && $past(mode_i.cls) == THMC_CLS_ONES |-> !run_o && count_value_o == 8'h00;
   endproperty
   a_osm: assert property (p_osm) else $error("one-shot match did not stop");
   property p_mom;
      match_o && $past(mode_i.cls) == THMC_CLS_MONO |-> run_o && count_value_o == 8'h00;
   endproperty
   a_mom: assert property (p_mom) else $error("monostable match wrong");
   // Low level holds the count at zero
   property p_lvl;
      (mode_i == 5'h06 && !debug_i && !ext_reset_signal_i && run_o) [*4] |-> count_value_o == 8'h00;
   endproperty
   a_lvl: assert property (p_lvl) else $error("count not held by low level");
   c_os: cover property (match_o && !run_o);
   c_mono: cover property (match_o && run_o && mode_i.cls == THMC_CLS_MONO);
   c_lvl: cover property (mode_i == 5'h06 && run_o && count_value_o == 8'h00);
endmodule : thmc_ctrl_monitor
bind thmc_ctrl thmc_ctrl_monitor u_mon (.clk_i, .nrst_i, .run_set_i, .run_clr_i, .mode_i,
   .debug_i, .ext_reset_signal_i, .run_o, .count_value_o, .match_o);

// >>> bench/timer_hlt_mode_control_bench.sv
// Testbench: mode scenarios of the timer mode control with a trigger source model
module timer_hlt_mode_control_bench;
   timeunit 1ns / 1ns;
   import thmc_pkg::*;
   // ==========================================================
   // Signals
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic run_set_i = 1'b0;
   logic run_clr_i = 1'b0;
   thmc_mode_t mode_i = 5'h00;
   logic [7:0] period_value_i = 8'hFF;
   logic debug_i = 1'b0;
   logic want = 1'b0; // Level asked of the source
   logic ext_reset_signal_i;
   logic run_o;
   logic [7:0] count_value_o;
   logic match_o;
   logic counting_o;
   logic [7:0] held; // Count snapshot
   int err_total = 0;
   int n_compared = 0;
   // Clock, 100 ns period
   always #50 clk_i = ~clk_i;
   thmc_ctrl dut (.clk_i, .nrst_i, .run_set_i, .run_clr_i, .mode_i, .period_value_i,
      .debug_i, .ext_reset_signal_i, .run_o, .count_value_o, .match_o, .counting_o);
   thmc_ers_model src (.clk_i(clk_i), .want_i(want), .ers_o(ext_reset_signal_i));
   // ==========================================================
   // Helpers
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : cyc
   task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic ok(input string nm, input logic c);
      chk(nm, {7'h00, c}, 8'h01);
   endtask : ok
   // One-cycle pulse on run set or run clear
   task automatic pulse(input logic set);
      run_set_i = set;
      run_clr_i = ~set;
      cyc(1);
      run_set_i = 1'b0;
      run_clr_i = 1'b0;
   endtask : pulse
   // Reset, load mode and period, set the run bit
   task automatic start(input logic [4:0] m, input logic [7:0] p);
      nrst_i = 1'b0;
      mode_i = m;
      period_value_i = p;
      cyc(3);
      nrst_i = 1'b1;
      cyc(1);
      pulse(1'b1);
   endtask : start
   // Bounded wait for the match pulse
   task automatic wait_match();
      int i;
      for (i = 0; i < 40 && match_o !== 1'b1; i++) cyc(1);
      ok("match", match_o);
   endtask : wait_match
   // ==========================================================
   // Scenarios
   task automatic t_modes();
      start(5'h08, 8'h02);
      wait_match();
      chk("os_run", {7'h00, run_o}, 8'h00);
      cyc(5);
      chk("os_stop", count_value_o, 8'h00);
      start(5'h00, 8'h03);
      wait_match();
      ok("free_run", run_o);
      ok("counting", counting_o);
      pulse(1'b0);
      cyc(4);
      chk("halted", {7'h00, counting_o}, 8'h00);
      $display("software modes done");
   endtask : t_modes
   task automatic t_edge();
      start(5'h04, 8'hFF);
      cyc(20);
      want = 1'b1;
      cyc(5);
      ok("edge_reset", count_value_o < 8'h06);
      want = 1'b0;
      cyc(8);
      debug_i = 1'b1;
      cyc(2);
      want = 1'b1;
      cyc(6);
      ok("debug_ignore", count_value_o > 8'h08);
      debug_i = 1'b0;
      want = 1'b0;
      start(5'h09, 8'hFF);
      cyc(8);
      chk("os_wait", count_value_o, 8'h00);
      want = 1'b1;
      cyc(6);
      ok("os_go", count_value_o != 8'h00);
      pulse(1'b0);
      cyc(1);
      pulse(1'b1);
      cyc(3);
      held = count_value_o;
      cyc(4);
      chk("rearm_wait", count_value_o, held);
      $display("edge modes done");
   endtask : t_edge
   task automatic t_mono_level();
      want = 1'b0;
      start(5'h11, 8'h03);
      cyc(3);
      want = 1'b1;
      wait_match();
      ok("mono_run", run_o);
      want = 1'b0;
      cyc(8);
      chk("mono_stop", count_value_o, 8'h00);
      want = 1'b1;
      wait_match();
      want = 1'b0;
      start(5'h06, 8'hFF);
      cyc(8);
      chk("lvl_hold", count_value_o, 8'h00);
      want = 1'b1;
      cyc(6);
      ok("lvl_free", count_value_o != 8'h00);
      start(5'h10, 8'h03);
      cyc(8);
      chk("rsvd_var", count_value_o, 8'h00);
      start(5'h18, 8'h03);
      cyc(8);
      chk("rsvd_cls", count_value_o, 8'h00);
      $display("monostable and level modes done");
   endtask : t_mono_level
   task automatic t_hw();
      start(5'h01, 8'hFF);
      cyc(8);
      ok("gate_run", count_value_o != 8'h00);
      want = 1'b0;
      cyc(3);
      held = count_value_o;
      cyc(4);
      chk("gate_halt", count_value_o, held);
      // first rise starts, later rise resets
      start(5'h0C, 8'h40);
      want = 1'b1;
      cyc(8);
      ok("os_edge_go", count_value_o != 8'h00);
      want = 1'b0;
      cyc(7);
      want = 1'b1;
      cyc(3);
      ok("os_edge_rst", count_value_o < 8'h04);
      want = 1'b0;
      start(5'h0E, 8'h40);
      want = 1'b1;
      cyc(10);
      ok("os_lvl_go", count_value_o != 8'h00);
      want = 1'b0;
      cyc(6);
      chk("os_lvl_rst", count_value_o, 8'h00);
      start(5'h16, 8'h40);
      cyc(4);
      chk("mono_lvl_wait", count_value_o, 8'h00);
      want = 1'b1;
      cyc(5);
      ok("mono_lvl_go", count_value_o != 8'h00);
      $display("hardware level and edge reset modes done");
   endtask : t_hw
   // Print counts and verdict, end the run
   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : give_verdict
   initial begin
      t_modes();
      t_edge();
      t_mono_level();
      t_hw();
      give_verdict();
   end
   // Watchdog against a hang
   initial begin
      #(2000 * 100);
      err_total++;
      give_verdict();
   end
endmodule : timer_hlt_mode_control_bench
